// [verilog/bpse_params.svh]
// Constants of the bridge parity and system error reporting block.
`ifndef BPSE_PARAMS_SVH
`define BPSE_PARAMS_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define BPSE_ADDR_W 4
`define BPSE_OFS_CTRL 4'h0
`define BPSE_OFS_STAT 4'h4
`define BPSE_OFS_CAUSE 4'h8
`define BPSE_OFS_DIS 4'hC

// ----------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------
`define BPSE_C_PPERR_EN 0
`define BPSE_C_SERR_EN 1
`define BPSE_C_SPERR_EN 2
`define BPSE_C_SERR_FWD 3
`define BPSE_C_MA_MODE 4
`define BPSE_C_MTO_EN 5
`define BPSE_CTRL_W 6
`define BPSE_CTRL_RST 6'h00

// ----------------------------------------------------------------------
// Status register fields, write one to clear
// ----------------------------------------------------------------------
`define BPSE_S_SIG 0
`define BPSE_S_RCV 1

// ----------------------------------------------------------------------
// Cause and disable fields
// ----------------------------------------------------------------------
`define BPSE_E_TA 0
`define BPSE_E_MA 1
`define BPSE_E_PWR 2
`define BPSE_E_PAR 3
`define BPSE_E_DWR 4
`define BPSE_E_DRR 5
`define BPSE_E_MTO 6
`define BPSE_E_FWD 7
`define BPSE_EV_N 8
`define BPSE_DIS_RST 8'h00

// ----------------------------------------------------------------------
// Retry limit
// ----------------------------------------------------------------------
`define BPSE_RETRY_W 25
`define BPSE_RETRY_LIM 25'h1000000

`endif

// [verilog/bpse_pkg.sv]
// Types of the bridge parity and system error reporting block.
package bpse_pkg;
  typedef enum logic [1:0] {
    BPSE_DIR_DOWN = 2'h1,
    BPSE_DIR_UP = 2'h2
  } bpse_dir_t;
endpackage

// [verilog/bpse_retry_cnt.sv]
// Retry counter for one queued transaction with a limit pulse.
`timescale 1ns/100ps
`include "bpse_params.svh"
module bpse_retry_cnt
  import bpse_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Counting
  input wire logic start,
  input wire logic retry,
  input wire logic done,
  // Limit reached, one-cycle pulse
  output logic limit
);

  logic [`BPSE_RETRY_W-1:0] cnt_reg;
  logic active_reg;

  // ----------------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_reg <= '0;
      active_reg <= 1'b0;
    end else if (start) begin
      cnt_reg <= '0;
      active_reg <= 1'b1;
    end else if (done || limit) begin
      active_reg <= 1'b0;
    end else if (active_reg && retry) begin
      cnt_reg <= cnt_reg + 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // Limit pulse
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      limit <= 1'b0;
    end else begin
      limit <= active_reg && !limit && !done && retry &&
        (cnt_reg == `BPSE_RETRY_LIM - 25'h0000001);
    end
  end

endmodule

// [verilog/bpse_core.sv]
// Parity error and system error reporting of a two-port bridge.
`timescale 1ns/100ps
`include "bpse_params.svh"
module bpse_core
  import bpse_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Register port
  input wire logic [`BPSE_ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Secondary parity event, one-cycle pulses
  input wire logic sec_data_perr,
  input wire logic sec_perr_role,
  input wire logic pri_perr_upd_dw,
  // Posted write parity report on the target bus
  input wire logic pw_perr_seen,
  input wire logic pw_perr_dir_up,
  input wire logic pw_perr_self,
  // Posted write termination
  input wire logic pw_target_abort,
  input wire logic pw_master_abort,
  // Retry counting per queue head
  input wire logic pw_start,
  input wire logic pw_retry,
  input wire logic pw_done,
  input wire logic dw_start,
  input wire logic dw_retry,
  input wire logic dw_done,
  input wire logic dr_start,
  input wire logic dr_retry,
  input wire logic dr_done,
  // Master timeout on a completed delayed transaction
  input wire logic dt_master_timeout,
  // Secondary system error input, active low
  input wire logic sec_serr_in_n,
  // Discard requests, one-cycle pulses
  output logic pw_discard,
  output logic dw_discard,
  output logic dr_discard,
  // Error pins, active low
  output logic sec_perr_n,
  output logic pri_serr_n
);

  logic [`BPSE_CTRL_W-1:0] ctrl_reg;
  logic [`BPSE_EV_N-1:0] dis_reg;
  logic [`BPSE_EV_N-1:0] cause_reg;
  logic sig_reg;
  logic rcv_reg;
  logic pw_lim;
  logic dw_lim;
  logic dr_lim;
  logic [`BPSE_EV_N-1:0] ev;
  logic [`BPSE_EV_N-1:0] ev_ok;
  logic serr_next;
  logic sperr_next;
  bpse_dir_t pw_dir;

  // Write-one-to-clear with hardware set winning over the clear.
  function automatic logic [`BPSE_EV_N-1:0] w1c(
    input logic [`BPSE_EV_N-1:0] cur,
    input logic [`BPSE_EV_N-1:0] clr,
    input logic [`BPSE_EV_N-1:0] set
  );
    w1c = (cur & ~clr) | set;
  endfunction

  // ----------------------------------------------------------------------
  // Retry counters
  // ----------------------------------------------------------------------
  bpse_retry_cnt u_pw_cnt (
    .clk(clk),
    .rst_n(rst_n),
    .start(pw_start),
    .retry(pw_retry),
    .done(pw_done),
    .limit(pw_lim)
  );

  bpse_retry_cnt u_dw_cnt (
    .clk(clk),
    .rst_n(rst_n),
    .start(dw_start),
    .retry(dw_retry),
    .done(dw_done),
    .limit(dw_lim)
  );

  bpse_retry_cnt u_dr_cnt (
    .clk(clk),
    .rst_n(rst_n),
    .start(dr_start),
    .retry(dr_retry),
    .done(dr_done),
    .limit(dr_lim)
  );

  // ----------------------------------------------------------------------
  // Event qualification
  // ----------------------------------------------------------------------
  always_comb begin
    pw_dir = pw_perr_dir_up ? BPSE_DIR_UP : BPSE_DIR_DOWN;
    ev = '0;
    ev[`BPSE_E_TA] = pw_target_abort;
    ev[`BPSE_E_MA] = pw_master_abort && ctrl_reg[`BPSE_C_MA_MODE];
    ev[`BPSE_E_PWR] = pw_lim;
    // Target-side report on either direction, never self-detected.
    ev[`BPSE_E_PAR] = pw_perr_seen && !pw_perr_self &&
      (pw_dir == BPSE_DIR_UP || pw_dir == BPSE_DIR_DOWN) &&
      ctrl_reg[`BPSE_C_PPERR_EN] && ctrl_reg[`BPSE_C_SPERR_EN];
    ev[`BPSE_E_DWR] = dw_lim;
    ev[`BPSE_E_DRR] = dr_lim;
    ev[`BPSE_E_MTO] = dt_master_timeout && ctrl_reg[`BPSE_C_MTO_EN];
    ev[`BPSE_E_FWD] = !sec_serr_in_n && ctrl_reg[`BPSE_C_SERR_FWD];
    ev_ok = ev & ~dis_reg;
    ev_ok[`BPSE_E_MTO] = ev[`BPSE_E_MTO];
    serr_next = ctrl_reg[`BPSE_C_SERR_EN] && (ev_ok != '0);
    // Secondary data parity error as write target or read initiator.
    sperr_next = ctrl_reg[`BPSE_C_SPERR_EN] &&
      ((sec_data_perr && sec_perr_role) ||
       (pri_perr_upd_dw && ctrl_reg[`BPSE_C_PPERR_EN]));
  end

  // ----------------------------------------------------------------------
  // Error pins
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pri_serr_n <= 1'b1;
      sec_perr_n <= 1'b1;
    end else begin
      pri_serr_n <= !serr_next;
      sec_perr_n <= !sperr_next;
    end
  end

  // ----------------------------------------------------------------------
  // Discard pulses
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pw_discard <= 1'b0;
      dw_discard <= 1'b0;
      dr_discard <= 1'b0;
    end else begin
      pw_discard <= pw_lim;
      dw_discard <= dw_lim;
      dr_discard <= dr_lim;
    end
  end

  // ----------------------------------------------------------------------
  // Control and disable registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl_reg <= `BPSE_CTRL_RST;
      dis_reg <= `BPSE_DIS_RST;
    end else if (reg_wr) begin
      if (reg_addr == `BPSE_OFS_CTRL) begin
        ctrl_reg <= reg_wdata[`BPSE_CTRL_W-1:0];
      end
      if (reg_addr == `BPSE_OFS_DIS) begin
        dis_reg <= reg_wdata[`BPSE_EV_N-1:0];
      end
    end
  end

  // ----------------------------------------------------------------------
  // Cause register
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cause_reg <= '0;
    end else begin
      cause_reg <= w1c(cause_reg,
        (reg_wr && reg_addr == `BPSE_OFS_CAUSE) ?
          reg_wdata[`BPSE_EV_N-1:0] : '0,
        serr_next ? ev_ok : '0);
    end
  end

  // ----------------------------------------------------------------------
  // Status flags
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sig_reg <= 1'b0;
      rcv_reg <= 1'b0;
    end else begin
      if (serr_next) begin
        sig_reg <= 1'b1;
      end else if (reg_wr && reg_addr == `BPSE_OFS_STAT &&
          reg_wdata[`BPSE_S_SIG]) begin
        sig_reg <= 1'b0;
      end
      if (serr_next && ev_ok[`BPSE_E_FWD]) begin
        rcv_reg <= 1'b1;
      end else if (reg_wr && reg_addr == `BPSE_OFS_STAT &&
          reg_wdata[`BPSE_S_RCV]) begin
        rcv_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      unique case (reg_addr)
        `BPSE_OFS_CTRL: begin
          reg_rdata <= {{(32-`BPSE_CTRL_W){1'b0}}, ctrl_reg};
        end
        `BPSE_OFS_STAT: begin
          reg_rdata <= {30'h00000000, rcv_reg, sig_reg};
        end
        `BPSE_OFS_CAUSE: begin
          reg_rdata <= {24'h000000, cause_reg};
        end
        `BPSE_OFS_DIS: begin
          reg_rdata <= {24'h000000, dis_reg};
        end
        default: begin
          reg_rdata <= '0;
        end
      endcase
    end else begin
      reg_rdata <= '0;
    end
  end

endmodule

// [tb/bpse_core_properties.sv]
// Concurrent checks on the ports of the reporting block.
`timescale 1ns/100ps
`include "bpse_params.svh"
module bpse_core_properties
  import bpse_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Register writes
  input wire logic [`BPSE_ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  // Events
  input wire logic sec_data_perr, sec_perr_role, pri_perr_upd_dw,
  input wire logic pw_perr_seen, pw_perr_self, pw_target_abort,
  input wire logic pw_master_abort, dt_master_timeout, sec_serr_in_n,
  // Outputs of the block
  input wire logic pw_discard, dw_discard, dr_discard,
  input wire logic sec_perr_n, pri_serr_n
);
  logic [5:0] ctl;
  logic [7:0] dis;
  logic ta_q, ma_q, par_q, fwd_q, mto_q, want, sp_want;

  // Shadow copies of control and disable, so causes can be judged.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctl <= 6'h00;
      dis <= 8'h00;
    end else if (reg_wr && reg_addr == `BPSE_OFS_CTRL) begin
      ctl <= reg_wdata[5:0];
    end else if (reg_wr && reg_addr == `BPSE_OFS_DIS) begin
      dis <= reg_wdata[7:0];
    end
  end

  assign ta_q = pw_target_abort && ctl[1] && !dis[0];
  assign ma_q = pw_master_abort && ctl[1] && ctl[4] && !dis[1];
  assign par_q = pw_perr_seen && !pw_perr_self && ctl[1] && ctl[0]
    && ctl[2] && !dis[3];
  assign fwd_q = !sec_serr_in_n && ctl[1] && ctl[3] && !dis[7];
  assign mto_q = dt_master_timeout && ctl[1] && ctl[5];
  assign want = ta_q || ma_q || par_q || fwd_q || mto_q;
  assign sp_want = ctl[2] && (sec_data_perr && sec_perr_role
    || pri_perr_upd_dw && ctl[0]);

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_serr;
    !pri_serr_n;
  endsequence
  sequence s_perr;
    !sec_perr_n;
  endsequence

  chk_ta_serr: assert property (ta_q |=> s_serr)
    else $error("target abort not reported");
  chk_ma_serr: assert property (ma_q |=> s_serr)
    else $error("master abort not reported");
  chk_par_serr: assert property (par_q |=> s_serr)
    else $error("posted write parity not reported");
  chk_fwd_serr: assert property (fwd_q |=> s_serr)
    else $error("secondary error not forwarded");
  chk_mto_serr: assert property (mto_q |=> s_serr)
    else $error("master timeout not reported");
  chk_serr_cause: assert property (s_serr |-> $past(want)
    || pw_discard || dw_discard || dr_discard)
    else $error("system error without cause");
  chk_perr_up: assert property (pri_perr_upd_dw && ctl[0] && ctl[2]
    |=> s_perr)
    else $error("upstream delayed write parity missed");
  chk_perr_sec: assert property (sec_data_perr && sec_perr_role
    && ctl[2] |=> s_perr)
    else $error("secondary data parity missed");
  chk_perr_src: assert property (s_perr |-> $past(sp_want))
    else $error("parity error without cause");
  chk_discard_pulse: assert property (pw_discard |=> !pw_discard)
    else $error("posted write discard longer than one cycle");
endmodule

bind bpse_core bpse_core_properties u_bpse_core_properties (.*);

// [tb/bpse_bus_model.sv]
// Far-side bus model that turns bench requests into bridge events.
`timescale 1ns/100ps
module bpse_bus_model (
  // Requests from the bench, one bit per event; the retry, start and done bits each feed all three queues
  input wire logic [12:0] ev,
  // Events seen on the two buses
  output logic pw_target_abort, pw_master_abort, pw_perr_seen,
  output logic pw_perr_dir_up, pw_perr_self, dt_master_timeout,
  output logic sec_serr_in_n, pri_perr_upd_dw, sec_data_perr,
  output logic sec_perr_role, pw_retry, dw_retry, dr_retry,
  output logic pw_start, dw_start, dr_start, pw_done, dw_done, dr_done
);
  assign {dt_master_timeout, pw_perr_self, pw_perr_dir_up, pw_perr_seen,
    pw_master_abort, pw_target_abort} = ev[5:0];
  // The secondary error line has a pull-up, so it idles high.
  assign sec_serr_in_n = ~ev[6];
  assign {sec_perr_role, sec_data_perr, pri_perr_upd_dw} = ev[9:7];
  assign {pw_retry, dw_retry, dr_retry} = {3{ev[10]}};
  assign {pw_start, dw_start, dr_start} = {3{ev[11]}};
  assign {pw_done, dw_done, dr_done} = {3{ev[12]}};
endmodule

// [tb/test_bpse_core.sv]
// Self-checking testbench of the reporting block.
`timescale 1ns/100ps
`include "bpse_params.svh"
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin n_fail++; \
  $display("unexpected at %0t got %0h exp %0h", $time, g, e); end end
module test_bpse_core;
  logic clk, rst_n, reg_wr, reg_rd;
  logic [3:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic [12:0] ev;
  logic sec_data_perr, sec_perr_role, pri_perr_upd_dw, pw_perr_seen;
  logic pw_perr_dir_up, pw_perr_self, pw_target_abort, pw_master_abort;
  logic pw_start, pw_retry, pw_done, dw_start, dw_retry, dw_done;
  logic dr_start, dr_retry, dr_done, dt_master_timeout, sec_serr_in_n;
  logic pw_discard, dw_discard, dr_discard, sec_perr_n, pri_serr_n;
  int n_fail, total_checks;
  localparam logic [12:0] e_ta = 13'h0001, e_ma = 13'h0002,
    e_ps = 13'h0004, e_up = 13'h0008, e_sf = 13'h0010, e_mt = 13'h0020,
    e_fw = 13'h0040, e_ud = 13'h0080, e_sd = 13'h0100, e_ro = 13'h0200,
    e_rt = 13'h0400, e_st = 13'h0800, e_dn = 13'h1000;

  bpse_core u_bpse_core (.*);
  bpse_bus_model u_bpse_bus_model (.*);

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic results;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd_chk(input logic [3:0] a, input logic [31:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    `CHK(reg_rdata, e)
  endtask

  // Pulses events for one cycle and looks at both pins a cycle later.
  task automatic fire(input logic [12:0] v, input logic s, input logic p);
    @(posedge clk);
    ev <= v;
    @(posedge clk);
    ev <= 13'h0000;
    #1;
    `CHK(pri_serr_n, s)
    `CHK(sec_perr_n, p)
  endtask

  task automatic clr;
    wr(`BPSE_OFS_CAUSE, 32'hFF);
    wr(`BPSE_OFS_STAT, 32'h3);
  endtask

  task automatic t_reset;
    for (int i = 0; i < 4; i++) rd_chk(4'(4 * i), 32'h0);
    wr(4'h2, 32'hFF);
    rd_chk(4'h2, 32'h0);
  endtask

  task automatic t_gate;
    fire(e_ta, 1'b1, 1'b1);
    rd_chk(`BPSE_OFS_CAUSE, 32'h0);
    wr(`BPSE_OFS_CTRL, 32'h2);
    fire(e_ta, 1'b0, 1'b1);
    rd_chk(`BPSE_OFS_STAT, 32'h1);
    repeat (5) @(posedge clk);
    rd_chk(`BPSE_OFS_CAUSE, 32'h1);
    clr;
    rd_chk(`BPSE_OFS_CAUSE, 32'h0);
    rd_chk(`BPSE_OFS_STAT, 32'h0);
  endtask

  task automatic t_abort;
    fire(e_ma, 1'b1, 1'b1);
    wr(`BPSE_OFS_CTRL, 32'h12);
    fire(e_ma, 1'b0, 1'b1);
    rd_chk(`BPSE_OFS_CAUSE, 32'h2);
    clr;
  endtask

  task automatic t_mask;
    wr(`BPSE_OFS_CTRL, 32'h2);
    wr(`BPSE_OFS_DIS, 32'h1);
    fire(e_ta, 1'b1, 1'b1);
    wr(`BPSE_OFS_DIS, 32'hFF);
    fire(e_mt, 1'b1, 1'b1);
    wr(`BPSE_OFS_CTRL, 32'h22);
    fire(e_mt, 1'b0, 1'b1);
    rd_chk(`BPSE_OFS_CAUSE, 32'h40);
    wr(`BPSE_OFS_DIS, 32'h0);
    clr;
  endtask

  task automatic t_fwd;
    wr(`BPSE_OFS_CTRL, 32'h2);
    fire(e_fw, 1'b1, 1'b1);
    wr(`BPSE_OFS_CTRL, 32'hA);
    fire(e_fw, 1'b0, 1'b1);
    rd_chk(`BPSE_OFS_STAT, 32'h3);
    rd_chk(`BPSE_OFS_CAUSE, 32'h80);
    clr;
  endtask

  task automatic par(input logic [12:0] v, input logic [31:0] c,
      input logic s);
    wr(`BPSE_OFS_CTRL, c);
    fire(v, s, 1'b1);
    rd_chk(`BPSE_OFS_CAUSE, s ? 32'h0 : 32'h8);
    clr;
  endtask

  task automatic t_parity;
    par(e_ps, 32'h7, 1'b0);
    par(e_ps | e_up, 32'h7, 1'b0);
    par(e_ps | e_sf, 32'h7, 1'b1);
    par(e_ps, 32'h3, 1'b1);
  endtask

  task automatic t_sec_perr;
    wr(`BPSE_OFS_CTRL, 32'h5);
    fire(e_ud, 1'b1, 1'b0);
    wr(`BPSE_OFS_CTRL, 32'h4);
    fire(e_ud, 1'b1, 1'b1);
    fire(e_sd | e_ro, 1'b1, 1'b0);
    fire(e_sd, 1'b1, 1'b1);
    wr(`BPSE_OFS_CTRL, 32'h1);
    fire(e_sd | e_ro, 1'b1, 1'b1);
  endtask

  task automatic t_retry;
    wr(`BPSE_OFS_CTRL, 32'h2);
    fire(e_st, 1'b1, 1'b1);
    repeat (3) fire(e_rt, 1'b1, 1'b1);
    @(posedge clk);
    #1;
    `CHK({pw_discard, dw_discard, dr_discard}, 3'h0)
    fire(e_dn, 1'b1, 1'b1);
  endtask

  initial begin
    #40000;
    n_fail++;
    results;
  end

  initial begin
    rst_n = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 32'h0;
    ev = 13'h0000;
    n_fail = 0;
    total_checks = 0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    t_reset;
    t_gate;
    t_abort;
    t_mask;
    t_fwd;
    t_parity;
    t_sec_perr;
    t_retry;
    results;
  end
endmodule
